/* File: port_cd_pins.sv */
// Pin logic for the whole first port and the whole second port
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module port_cd_pins (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] first_port_in,
  output port_cd_pkg::pad_drive_s first_pad,
  input wire logic [7:0] second_port_in,
  output port_cd_pkg::pad_drive_s second_pad,
  output logic [7:0] second_pullup,
  output logic second_ttl_select,
  output logic [7:0] second_port_levels,
  input wire logic second_ccp_pin_select,
  input wire port_cd_pkg::periph_drive_s periph,
  output port_cd_pkg::periph_feed_s feed,
  output logic [1:0] i2c_buffer_select,
  output logic i2c_buffer_smbus,
  input wire logic [7:0] ext_bus_ad_out,
  input wire logic ext_bus_ad_oe,
  input wire logic parallel_read_oe,
  output logic ext_bus_disable,
  output logic parallel_slave_mode_bit
);
  import port_cd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: the first stage is read by the second only

  logic [7:0] first_meta;
  logic [7:0] first_sync;
  logic [7:0] second_meta;
  logic [7:0] second_sync;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_meta <= 8'h00;
      first_sync <= 8'h00;
      second_meta <= 8'h00;
      second_sync <= 8'h00;
    end else begin
      first_meta <= first_port_in;
      first_sync <= first_meta;
      second_meta <= second_port_in;
      second_sync <= second_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] first_port_latch;
  logic [7:0] first_port_direction;
  logic [7:0] second_port_latch;
  logic [7:0] second_port_direction;
  logic second_port_pullup_enable;
  logic [7:0] next_first_latch;
  logic [7:0] next_first_dir;
  logic [7:0] next_second_latch;
  logic [7:0] next_second_dir;
  logic next_ext_bus_disable;
  logic next_pullup_enable;
  logic next_parallel_mode;
  logic [7:0] next_rdata;

  always_comb begin
    next_first_latch = first_port_latch;
    next_first_dir = first_port_direction;
    next_second_latch = second_port_latch;
    next_second_dir = second_port_direction;
    next_ext_bus_disable = ext_bus_disable;
    next_pullup_enable = second_port_pullup_enable;
    next_parallel_mode = parallel_slave_mode_bit;
    next_rdata = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        OFS_FIRST_PINS, OFS_FIRST_LATCH:
          next_first_latch = reg_wdata;
        OFS_FIRST_DIR: next_first_dir = reg_wdata;
        OFS_SECOND_PINS, OFS_SECOND_LATCH:
          next_second_latch = reg_wdata;
        OFS_SECOND_DIR: next_second_dir = reg_wdata;
        OFS_MEMORY_CONTROL:
          next_ext_bus_disable = reg_wdata[BIT_EXT_BUS_DISABLE];
        OFS_SEVENTH_PORT:
          next_pullup_enable = reg_wdata[BIT_PULLUP_ENABLE];
        OFS_PARALLEL_CONTROL:
          next_parallel_mode = reg_wdata[BIT_PARALLEL_MODE];
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        OFS_FIRST_PINS: next_rdata = first_sync;
        OFS_FIRST_LATCH: next_rdata = first_port_latch;
        OFS_FIRST_DIR: next_rdata = first_port_direction;
        OFS_SECOND_PINS: next_rdata = second_sync;
        OFS_SECOND_LATCH: next_rdata = second_port_latch;
        OFS_SECOND_DIR: next_rdata = second_port_direction;
        OFS_MEMORY_CONTROL:
          next_rdata[BIT_EXT_BUS_DISABLE] = ext_bus_disable;
        OFS_SEVENTH_PORT:
          next_rdata[BIT_PULLUP_ENABLE] = second_port_pullup_enable;
        OFS_PARALLEL_CONTROL:
          next_rdata[BIT_PARALLEL_MODE] = parallel_slave_mode_bit;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_port_latch <= RST_LATCH;
      first_port_direction <= RST_DIR;
      second_port_latch <= RST_LATCH;
      second_port_direction <= RST_DIR;
      ext_bus_disable <= RST_EXT_BUS_DISABLE;
      second_port_pullup_enable <= RST_PULLUP_ENABLE;
      parallel_slave_mode_bit <= RST_PARALLEL_MODE;
      reg_rdata <= 8'h00;
    end else begin
      first_port_latch <= next_first_latch;
      first_port_direction <= next_first_dir;
      second_port_latch <= next_second_latch;
      second_port_direction <= next_second_dir;
      ext_bus_disable <= next_ext_bus_disable;
      second_port_pullup_enable <= next_pullup_enable;
      parallel_slave_mode_bit <= next_parallel_mode;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad steering, registered so every output leaves a flip-flop

  pad_drive_s next_first_pad;
  pad_drive_s next_second_pad;
  logic [7:0] next_pullup;
  logic next_ttl;
  periph_feed_s next_feed;
  logic [1:0] next_i2c_sel;

  always_comb begin
    next_first_pad.out = first_port_latch;
    next_first_pad.oe = ~first_port_direction;
    // Capture/compare may tristate itself during a PWM shutdown
    if (second_ccp_pin_select && periph.ccp2_en &&
        !first_port_direction[PIN_CCP]) begin
      next_first_pad.out[PIN_CCP] = periph.ccp2_out;
      next_first_pad.oe[PIN_CCP] = periph.ccp2_oe;
    end
    if (periph.spi_en && !first_port_direction[PIN_CLK])
      next_first_pad.out[PIN_CLK] = periph.spi_clk_out;
    // I2C lines are open drain: drive low or release
    if (periph.i2c_en && first_port_direction[PIN_CLK]) begin
      next_first_pad.out[PIN_CLK] = 1'b0;
      next_first_pad.oe[PIN_CLK] = periph.i2c_clock_low;
    end
    if (periph.i2c_en && first_port_direction[PIN_DATA]) begin
      next_first_pad.out[PIN_DATA] = 1'b0;
      next_first_pad.oe[PIN_DATA] = periph.i2c_data_low;
    end
    if (periph.spi_en && !first_port_direction[PIN_SPI_OUT])
      next_first_pad.out[PIN_SPI_OUT] = periph.spi_out_first;
    if (periph.serial_en && first_port_direction[PIN_TX]) begin
      next_first_pad.out[PIN_TX] = periph.serial_transmit_first;
      next_first_pad.oe[PIN_TX] = !periph.serial_sync ||
                                  periph.serial_clk_master;
    end
    // Sync data pin drives only while the transceiver sends
    if (periph.serial_en && periph.serial_sync &&
        first_port_direction[PIN_RX]) begin
      next_first_pad.out[PIN_RX] = periph.serial_transmit_first;
      next_first_pad.oe[PIN_RX] = periph.serial_data_drive;
    end

    next_feed.ccp2_capture_in = second_ccp_pin_select &
                                first_sync[PIN_CCP];
    next_feed.spi_clk_in = first_sync[PIN_CLK];
    next_feed.i2c_clock_first = first_port_direction[PIN_CLK] &
                                first_sync[PIN_CLK];
    next_feed.i2c_data_first = first_port_direction[PIN_DATA] &
                               first_sync[PIN_DATA];
    next_feed.spi_in_first = first_port_direction[PIN_DATA] &
                             first_sync[PIN_DATA];
    next_feed.serial_sync_clock_first = first_sync[PIN_TX];
    next_feed.serial_receive_first = first_port_direction[PIN_RX] &
                                     first_sync[PIN_RX];
    next_feed.serial_sync_data_first = first_sync[PIN_RX];
    next_i2c_sel = {2{periph.i2c_en}} &
                   first_port_direction[PIN_DATA:PIN_CLK];

    // Memory bus first, then parallel port, then plain port
    if (!ext_bus_disable) begin
      next_second_pad.out = ext_bus_ad_out;
      next_second_pad.oe = {8{ext_bus_ad_oe}};
    end else if (parallel_slave_mode_bit) begin
      next_second_pad.out = second_port_latch;
      next_second_pad.oe = {8{parallel_read_oe}};
    end else begin
      next_second_pad.out = second_port_latch;
      next_second_pad.oe = ~second_port_direction;
    end
    next_pullup = {8{second_port_pullup_enable}} &
                  ~next_second_pad.oe;
    next_ttl = parallel_slave_mode_bit || !ext_bus_disable;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_pad <= '{out: 8'h00, oe: 8'h00};
      second_pad <= '{out: 8'h00, oe: 8'h00};
      second_pullup <= 8'h00;
      second_ttl_select <= 1'b0;
      second_port_levels <= 8'h00;
      feed <= '0;
      i2c_buffer_select <= 2'h0;
      i2c_buffer_smbus <= 1'b0;
    end else begin
      first_pad <= next_first_pad;
      second_pad <= next_second_pad;
      second_pullup <= next_pullup;
      second_ttl_select <= next_ttl;
      second_port_levels <= second_sync;
      feed <= next_feed;
      i2c_buffer_select <= next_i2c_sel;
      i2c_buffer_smbus <= periph.i2c_smbus;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence latch_write_s;
    reg_write && reg_addr == OFS_SECOND_LATCH;
  endsequence

  sequence latch_read_s;
    reg_read && reg_addr == OFS_SECOND_LATCH && !reg_write;
  endsequence

  plain_direction_a: assert property (
    ext_bus_disable && !parallel_slave_mode_bit |=>
      second_pad.oe == ~$past(second_port_direction) &&
      second_pad.out == $past(second_port_latch))
    else $error("second port drive does not follow direction");

  latch_readback_a: assert property (
    latch_write_s ##1 latch_read_s |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("latch read does not return written value");

  reset_inputs_a: assert property (
    $rose(rstn) |-> second_pad.oe == 8'h00 &&
      second_port_direction == RST_DIR)
    else $error("second port not input after reset");

  bus_override_a: assert property (
    !ext_bus_disable |=> second_pad.out == $past(ext_bus_ad_out) &&
      second_pad.oe == {8{$past(ext_bus_ad_oe)}})
    else $error("memory bus does not own the second port");

  pullup_global_a: assert property (
    !second_port_pullup_enable |=> second_pullup == 8'h00)
    else $error("pull-ups on while disabled");

  pullup_output_a: assert property (
    (second_pullup & second_pad.oe) == 8'h00)
    else $error("pull-up on a driving pin");

  reset_pullup_a: assert property (
    $rose(rstn) |-> second_pullup == 8'h00 &&
      !second_port_pullup_enable)
    else $error("pull-ups on after reset");

  parallel_drive_a: assert property (
    ext_bus_disable && parallel_slave_mode_bit |=>
      second_pad.oe == {8{$past(parallel_read_oe)}} &&
      second_pad.out == $past(second_port_latch))
    else $error("parallel port drive wrong");

  ttl_select_a: assert property (
    ext_bus_disable |=>
      second_ttl_select == $past(parallel_slave_mode_bit))
    else $error("buffer type does not follow parallel mode");

  spi_output_a: assert property (
    periph.spi_en && !first_port_direction[PIN_SPI_OUT] |=>
      first_pad.out[PIN_SPI_OUT] == $past(periph.spi_out_first))
    else $error("spi output not on pin 5");

  direction_read_a: assert property (
    reg_read && reg_addr == OFS_FIRST_DIR |=>
      reg_rdata == $past(first_port_direction))
    else $error("direction read not stored value");

endmodule // port_cd_pins
`default_nettype wire

/* File: port_cd_pkg.sv */
// Package: register map, reset values, bit positions and carriers
`default_nettype none
package port_cd_pkg;
  localparam logic [7:0] OFS_FIRST_PINS = 8'h00;
  localparam logic [7:0] OFS_FIRST_LATCH = 8'h04;
  localparam logic [7:0] OFS_FIRST_DIR = 8'h08;
  localparam logic [7:0] OFS_SECOND_PINS = 8'h0C;
  localparam logic [7:0] OFS_SECOND_LATCH = 8'h10;
  localparam logic [7:0] OFS_SECOND_DIR = 8'h14;
  localparam logic [7:0] OFS_MEMORY_CONTROL = 8'h18;
  localparam logic [7:0] OFS_SEVENTH_PORT = 8'h1C;
  localparam logic [7:0] OFS_PARALLEL_CONTROL = 8'h20;

  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic RST_EXT_BUS_DISABLE = 1'b1;
  localparam logic RST_PULLUP_ENABLE = 1'b0;
  localparam logic RST_PARALLEL_MODE = 1'b0;

  localparam int unsigned BIT_EXT_BUS_DISABLE = 7;
  localparam int unsigned BIT_PULLUP_ENABLE = 7;
  localparam int unsigned BIT_PARALLEL_MODE = 4;

  localparam int unsigned PIN_CCP = 1;
  localparam int unsigned PIN_CLK = 3;
  localparam int unsigned PIN_DATA = 4;
  localparam int unsigned PIN_SPI_OUT = 5;
  localparam int unsigned PIN_TX = 6;
  localparam int unsigned PIN_RX = 7;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad_drive_s;

  typedef struct packed {
    logic ccp2_en;
    logic ccp2_out;
    logic ccp2_oe;
    logic spi_en;
    logic spi_clk_master;
    logic spi_clk_out;
    logic spi_out_first;
    logic i2c_en;
    logic i2c_smbus;
    logic i2c_clock_low;
    logic i2c_data_low;
    logic serial_en;
    logic serial_sync;
    logic serial_clk_master;
    logic serial_transmit_first;
    logic serial_data_drive;
  } periph_drive_s;

  typedef struct packed {
    logic ccp2_capture_in;
    logic spi_clk_in;
    logic spi_in_first;
    logic i2c_clock_first;
    logic i2c_data_first;
    logic serial_sync_clock_first;
    logic serial_receive_first;
    logic serial_sync_data_first;
  } periph_feed_s;
endpackage
`default_nettype wire

/* File: pin_world.sv */
// Far side of the pins: pads, external drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic ref_clk,
  input wire port_cd_pkg::pad_drive_s first_pad,
  input wire port_cd_pkg::pad_drive_s second_pad,
  input wire logic [7:0] second_pullup,
  input wire logic [7:0] first_ext,
  input wire logic [7:0] first_ext_en,
  input wire logic [7:0] second_ext,
  input wire logic [7:0] second_ext_en,
  output logic [7:0] first_port_in,
  output logic [7:0] second_port_in
);
  import port_cd_pkg::*;
  // Undriven lines wander, so a stale level never passes for a real one
  logic [7:0] first_float = 8'h5A;
  logic [7:0] second_float = 8'hA5;
  always_ff @(posedge ref_clk) begin
    first_float <= ~first_port_in;
    second_float <= ~second_port_in;
  end
  // Pad drive wins; contention is not modelled
  assign first_port_in = first_pad.oe & first_pad.out | ~first_pad.oe &
    (first_ext_en & first_ext | ~first_ext_en & first_float);
  assign second_port_in = second_pad.oe & second_pad.out | ~second_pad.oe &
    (second_ext_en & second_ext | ~second_ext_en &
    (second_pullup | second_float));
endmodule // pin_world
`default_nettype wire

/* File: test_port_cd_pins.sv */
// Self-checking bench for the port pin logic
`timescale 1ns/1ps
`default_nettype none
module test_port_cd_pins;
  import port_cd_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, first_port_in, second_port_in, second_pullup;
  logic [7:0] second_port_levels, bus_out = 8'h00;
  pad_drive_s first_pad, second_pad;
  logic second_ttl_select, i2c_buffer_smbus, ext_bus_disable;
  logic parallel_slave_mode_bit, bus_oe = 1'b0, par_oe = 1'b0;
  logic ccp_sel = 1'b0;
  periph_drive_s periph = '0;
  periph_feed_s feed;
  logic [1:0] i2c_buffer_select;
  logic [7:0] c_ext = 8'h00;
  logic [7:0] d_ext = 8'h00;
  logic [7:0] d_ext_en = 8'hFF;
  int n_fail = 0;
  int checks_done = 0;
  logic rd_d = 1'b0;
  logic snap = 1'b0;
  logic [7:0] rq[$], pq[$];
  int ps[$];
  logic [7:0] ra [8] = '{OFS_FIRST_DIR, OFS_SECOND_DIR, OFS_FIRST_LATCH,
    OFS_SECOND_LATCH, OFS_MEMORY_CONTROL, OFS_SEVENTH_PORT,
    OFS_PARALLEL_CONTROL, 8'h24};
  logic [7:0] rv [8] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h00};
  port_cd_pins uut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .first_port_in(first_port_in),
    .first_pad(first_pad), .second_port_in(second_port_in),
    .second_pad(second_pad), .second_pullup(second_pullup),
    .second_ttl_select(second_ttl_select),
    .second_port_levels(second_port_levels),
    .second_ccp_pin_select(ccp_sel), .periph(periph), .feed(feed),
    .i2c_buffer_select(i2c_buffer_select),
    .i2c_buffer_smbus(i2c_buffer_smbus), .ext_bus_ad_out(bus_out),
    .ext_bus_ad_oe(bus_oe), .parallel_read_oe(par_oe),
    .ext_bus_disable(ext_bus_disable),
    .parallel_slave_mode_bit(parallel_slave_mode_bit));
  pin_world world (.ref_clk(ref_clk), .first_pad(first_pad),
    .second_pad(second_pad), .second_pullup(second_pullup),
    .first_ext(c_ext), .first_ext_en(8'hFF), .second_ext(d_ext),
    .second_ext_en(d_ext_en), .first_port_in(first_port_in),
    .second_port_in(second_port_in));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  // Write then read the same address with no idle cycle between
  task automatic wr_rd(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    rq.push_back(d);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  // Snapshot requests go through a queue so the watcher stays in order
  task automatic look(int s, logic [7:0] e);
    @(posedge ref_clk);
    ps.push_back(s);
    pq.push_back(e);
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
  endtask
  function automatic logic [7:0] pick(int s);
    case (s)
      0: return second_pad.out;
      1: return second_pad.oe;
      2: return second_pullup;
      3: return first_pad.out;
      4: return first_pad.oe;
      5: return feed;
      6: return {i2c_buffer_select, i2c_buffer_smbus, second_ttl_select,
        ext_bus_disable, parallel_slave_mode_bit, 2'b00};
      default: return second_port_levels;
    endcase
  endfunction
  always @(posedge ref_clk) rd_d <= reg_read;
  always @(negedge ref_clk) begin
    if (rd_d && rq.size() > 0) cmp(reg_rdata, rq.pop_front());
    if (snap && pq.size() > 0) cmp(pick(ps.pop_front()), pq.pop_front());
  end
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 5);
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] dir, lat, x, o, en, bo, xe;
    logic ebd, pm, pu, boe, pro, cs;
    periph_drive_s p;
    void'($urandom(32'h1722));
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    look(1, 8'h00);
    look(2, 8'h00);
    look(4, 8'h00);
    look(6, 8'h08);
    wr(8'h24, 8'hFF);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 24; i++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      x = 8'($urandom);
      bo = 8'($urandom);
      {ebd, pm, pu, boe, pro} = {(i % 4) != 0, 4'($urandom)};
      d_ext <= x;
      bus_out <= bo;
      bus_oe <= boe;
      par_oe <= pro;
      wr(OFS_SECOND_DIR, dir);
      wr((i % 2) ? OFS_SECOND_PINS : OFS_SECOND_LATCH, lat);
      wr(OFS_MEMORY_CONTROL, {ebd, 7'h7F});
      wr(OFS_SEVENTH_PORT, {pu, 7'h7F});
      wr(OFS_PARALLEL_CONTROL, {3'h7, pm, 4'hF});
      repeat (4) @(posedge ref_clk);
      o = ebd ? lat : bo;
      en = !ebd ? {8{boe}} : pm ? {8{pro}} : ~dir;
      // Undriven pins must rest on a pull-up to have a known level
      xe = 8'($urandom) | ~(pu ? ~en : 8'h00);
      d_ext_en <= xe;
      look(0, o);
      look(1, en);
      look(2, pu ? ~en : 8'h00);
      look(6, {3'b000, pm | ~ebd, ebd, pm, 2'b00});
      look(7, en & o | ~en & (xe & x | ~xe));
      rd(OFS_SECOND_PINS, en & o | ~en & (xe & x | ~xe));
      wr_rd(OFS_SECOND_LATCH, lat);
      rd(OFS_SECOND_DIR, dir);
      rd(OFS_MEMORY_CONTROL, {ebd, 7'h00});
      rd(OFS_SEVENTH_PORT, {pu, 7'h00});
      rd(OFS_PARALLEL_CONTROL, {3'h0, pm, 4'h0});
    end
    for (int i = 0; i < 24; i++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      x = 8'($urandom);
      p = periph_drive_s'(16'($urandom));
      cs = 1'($urandom);
      periph <= p;
      ccp_sel <= cs;
      c_ext <= x;
      wr(OFS_FIRST_DIR, dir);
      wr(OFS_FIRST_LATCH, lat);
      repeat (4) @(posedge ref_clk);
      o = lat;
      en = ~dir;
      if (cs && p.ccp2_en && !dir[1]) begin
        o[1] = p.ccp2_out;
        en[1] = p.ccp2_oe;
      end
      if (p.spi_en && !dir[3]) o[3] = p.spi_clk_out;
      if (p.i2c_en && dir[3]) {o[3], en[3]} = {1'b0, p.i2c_clock_low};
      if (p.i2c_en && dir[4]) {o[4], en[4]} = {1'b0, p.i2c_data_low};
      if (p.spi_en && !dir[5]) o[5] = p.spi_out_first;
      if (p.serial_en && dir[6]) begin
        o[6] = p.serial_transmit_first;
        en[6] = !p.serial_sync | p.serial_clk_master;
      end
      if (p.serial_en && p.serial_sync && dir[7]) begin
        o[7] = p.serial_transmit_first;
        en[7] = p.serial_data_drive;
      end
      look(3, o);
      look(4, en);
      rd(OFS_FIRST_DIR, dir);
      rd(OFS_FIRST_PINS, en & o | ~en & x);
    end
    // Slave serial and I2C inputs: every upper pin is an input
    wr(OFS_MEMORY_CONTROL, 8'h80);
    wr(OFS_PARALLEL_CONTROL, 8'h00);
    wr(OFS_FIRST_DIR, 8'hFF);
    periph <= '{i2c_en: 1'b1, i2c_smbus: 1'b1, serial_en: 1'b1,
      serial_sync: 1'b1, default: 1'b0};
    for (int i = 0; i < 8; i++) begin
      x = 8'($urandom);
      cs = 1'($urandom);
      c_ext <= x;
      ccp_sel <= cs;
      repeat (4) @(posedge ref_clk);
      look(5, {cs & x[1], x[3], x[4], x[3], x[4], x[6], x[7],
        x[7]});
      look(6, 8'hE8);
      rd(OFS_FIRST_DIR, 8'hFF);
    end
    close_out();
  end
endmodule // test_port_cd_pins
`default_nettype wire
